// ### imcm_conn_mgr.v
// Behaviour
// - on sample expiry with an owner connected, convert every channel and store results in channel memory
// - after that refresh, multicast fresh channels plus status on local backplane
// - on packet expiry, multicast stored memory without new conversion
// - every sample operation restarts the packet timer
// - remote chassis: both intervals multicast locally; packet interval sets network rate
// - accept listen-only connection without configuration while an owner exists
// - multicast only with an owner; losing all owners drops every listener
// - first owner configuration establishes connection and becomes stored configuration
// - later owner with matching configuration is accepted
// - later owner with differing configuration is refused with error answer
// - keep operating while any single owner connection remains
// - comparison applies when revision selector is 1; selector 0 undefined
// - changed configuration from the sole existing owner is adopted silently; with other owners connected it is refused
// - multiple owners allowed only for input device, all identical
// - multicast periodically on own initiative, never polled
`include "imcm_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module imcm_conn_mgr #(
    // cycles per millisecond tick; lowered only to shorten simulation
    parameter TICK_CYCLES = `IMCM_TICK_CYCLES
) (
    // clock and reset
    input  wire                                  ref_clk,
    input  wire                                  reset,
    // device setup
    input  wire                                  is_input_dev,
    input  wire                                  remote_chassis,
    input  wire [`IMCM_IVL_W-1:0]                sample_interval,
    input  wire [`IMCM_IVL_W-1:0]                packet_interval,
    // connection requests
    input  wire                                  req_valid,
    input  wire [1:0]                            req_kind,
    input  wire [1:0]                            req_slot,
    input  wire [`IMCM_CFG_W-1:0]                req_cfg,
    input  wire                                  req_rev_sel,
    // connection answers
    output reg                                   ans_valid,
    output reg  [1:0]                            ans_code,
    output reg  [`IMCM_OWN_N-1:0]                owner_conn,
    output reg  [`IMCM_LSN_N-1:0]                listen_conn,
    output reg  [`IMCM_CFG_W-1:0]                cur_cfg,
    // converter
    output reg                                   conv_start,
    input  wire                                  conv_done,
    input  wire [`IMCM_CH_N*`IMCM_CH_W-1:0]      conv_data,
    // multicast
    output reg                                   mcast_valid,
    output reg                                   mcast_fresh,
    output reg  [`IMCM_CH_N*`IMCM_CH_W-1:0]      mcast_data,
    output reg  [7:0]                            mcast_status,
    output reg                                   net_send
);

// ****************************************
// millisecond time base
// ****************************************
reg  [`IMCM_TICK_W-1:0] tick_cnt_q;
reg                     tick_q;
always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
        tick_cnt_q <= {`IMCM_TICK_W{1'b0}};
        tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES - 1) begin
        tick_cnt_q <= {`IMCM_TICK_W{1'b0}};
        tick_q     <= 1'b1;
    end else begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
        tick_q     <= 1'b0;
    end
end

// a zero interval would stall the counter, so it runs as one tick
function [`IMCM_IVL_W-1:0] reload;
    input [`IMCM_IVL_W-1:0] ivl;
    begin
        reload = (ivl == {`IMCM_IVL_W{1'b0}}) ? {{(`IMCM_IVL_W-1){1'b0}}, 1'b1} : ivl;
    end
endfunction

// ****************************************
// connection bookkeeping
// ****************************************
// owners gate listeners and every multicast
wire any_owner = |owner_conn;
wire [`IMCM_OWN_N-1:0] slot_bit = {{(`IMCM_OWN_N-1){1'b0}}, 1'b1} << req_slot;
always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
        ans_valid   <= 1'b0;
        ans_code    <= 2'h0;
        owner_conn  <= {`IMCM_OWN_N{1'b0}};
        listen_conn <= {`IMCM_LSN_N{1'b0}};
        cur_cfg     <= {`IMCM_CFG_W{1'b0}};
    end else begin
        ans_valid <= 1'b0;
        if (!any_owner)
            listen_conn <= {`IMCM_LSN_N{1'b0}};
        if (req_valid) begin
            ans_valid <= req_kind != `IMCM_REQ_DROP;
            ans_code  <= `IMCM_ANS_REJ;
            case (req_kind)
                `IMCM_REQ_OWNER: begin
                    // first owner, or the sole owner re-sending: config adopted
                    if (!any_owner || (owner_conn == slot_bit)) begin
                        owner_conn <= owner_conn | slot_bit;
                        cur_cfg    <= req_cfg;
                        ans_code   <= `IMCM_ANS_OK;
                    end else if (is_input_dev && req_rev_sel && req_cfg == cur_cfg) begin
                        owner_conn <= owner_conn | slot_bit;
                        ans_code   <= `IMCM_ANS_OK;
                    end
                    // otherwise refused
                end
                `IMCM_REQ_LISTEN: begin
                    if (any_owner) begin
                        listen_conn <= listen_conn | slot_bit;
                        ans_code    <= `IMCM_ANS_OK;
                    end
                end
                `IMCM_REQ_DROP: begin
                    // drop carries no answer
                    owner_conn  <= owner_conn & ~slot_bit;
                    listen_conn <= listen_conn & ~slot_bit;
                end
                default: ans_code <= `IMCM_ANS_REJ;
            endcase
        end
    end
end

// ****************************************
// schedule state machine
// ****************************************
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_CONV = 3'b010;
localparam [2:0] ST_SEND = 3'b100;
reg  [2:0]             state_q;
reg  [`IMCM_IVL_W-1:0] smp_cnt_q;
reg  [`IMCM_IVL_W-1:0] pkt_cnt_q;
reg                    smp_due_q;
// channel memory
reg  [`IMCM_CH_N*`IMCM_CH_W-1:0] chan_mem_q;
always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
        state_q      <= ST_IDLE;
        smp_cnt_q    <= `IMCM_IVL_RST;
        pkt_cnt_q    <= `IMCM_IVL_RST;
        smp_due_q    <= 1'b0;
        chan_mem_q   <= {(`IMCM_CH_N*`IMCM_CH_W){1'b0}};
        conv_start   <= 1'b0;
        mcast_valid  <= 1'b0;
        mcast_fresh  <= 1'b0;
        mcast_data   <= {(`IMCM_CH_N*`IMCM_CH_W){1'b0}};
        mcast_status <= 8'h00;
        net_send     <= 1'b0;
    end else begin
        conv_start  <= 1'b0;
        mcast_valid <= 1'b0;
        net_send    <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                // a due sample outranks a packet resend in the same cycle
                if (smp_due_q && any_owner) begin
                    smp_due_q  <= 1'b0;
                    conv_start <= 1'b1;
                    state_q    <= ST_CONV;
                end else begin
                    if (smp_due_q)
                        smp_due_q <= 1'b0; // no owner: skip
                    if (tick_q) begin
                        if (pkt_cnt_q <= 1) begin
                            pkt_cnt_q <= reload(packet_interval);
                            if (any_owner) begin
                                mcast_valid  <= 1'b1;
                                mcast_fresh  <= 1'b0;
                                mcast_data   <= chan_mem_q;
                                // status: remote flag, fresh flag, owner bitmap
                                mcast_status <= {2'h0, remote_chassis, 1'b0, owner_conn};
                                // network forwarding follows the packet interval only
                                net_send     <= remote_chassis;
                            end
                        end else
                            pkt_cnt_q <= pkt_cnt_q - 1'b1;
                    end
                end
            end
            ST_CONV: begin
                // packet expiries during conversion are absorbed by the restart below
                if (conv_done) begin
                    chan_mem_q <= conv_data;
                    state_q    <= ST_SEND;
                end
            end
            ST_SEND: begin
                // restart so the next resend is a full interval away
                pkt_cnt_q <= reload(packet_interval);
                state_q   <= ST_IDLE;
                if (any_owner) begin
                    mcast_valid  <= 1'b1;
                    mcast_fresh  <= 1'b1;
                    mcast_data   <= chan_mem_q;
                    mcast_status <= {2'h0, remote_chassis, 1'b1, owner_conn};
                end
            end
            default: state_q <= ST_IDLE;
        endcase
        // after the case: a new expiry beats the clear of the old one
        // independent sample down-counter
        if (tick_q) begin
            if (smp_cnt_q <= 1) begin
                smp_cnt_q <= reload(sample_interval);
                smp_due_q <= 1'b1;
            end else
                smp_cnt_q <= smp_cnt_q - 1'b1;
        end
    end
end

endmodule
`default_nettype wire

// ### imcm_defs.vh
`ifndef IMCM_DEFS_VH
`define IMCM_DEFS_VH
// ****************************************
// time base
// ****************************************
`define IMCM_CLK_HZ          100000000
`define IMCM_TICK_MS         1
`define IMCM_TICK_CYCLES     ((`IMCM_CLK_HZ / 1000) * `IMCM_TICK_MS)
`define IMCM_TICK_W          17
// ****************************************
// widths and reset values
// ****************************************
`define IMCM_IVL_W           16
`define IMCM_CFG_W           32
`define IMCM_CH_N            8
`define IMCM_CH_W            16
`define IMCM_OWN_N           4
`define IMCM_LSN_N           4
`define IMCM_IVL_RST         16'h0064
// ****************************************
// connection request kinds
// ****************************************
`define IMCM_REQ_OWNER       2'h1
`define IMCM_REQ_LISTEN      2'h2
`define IMCM_REQ_DROP        2'h3
// ****************************************
// answer codes
// ****************************************
`define IMCM_ANS_OK          2'h1
`define IMCM_ANS_REJ         2'h2
`endif

// ### imcm_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module imcm_conv_model #(parameter int DLY = 3) (
    // converter handshake
    input  wire logic         ref_clk,
    input  wire logic         conv_start,
    output logic              conv_done,
    output logic [127:0]      conv_data
);
    int         cnt_q = 0;
    logic [15:0] seq_q = 16'h0;
    initial conv_done = 1'b0;
    initial conv_data = 128'h0;
    always @(posedge ref_clk) begin
        conv_done <= 1'b0;
        // data only meaningful beside done, so it toggles otherwise
        conv_data <= ~conv_data;
        if (conv_start) begin
            cnt_q <= DLY;
        end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
        end else if (cnt_q == 1) begin
            cnt_q <= 0;
            seq_q <= seq_q + 16'h1;
            conv_done <= 1'b1;
            conv_data <= {8{seq_q + 16'h1}};
        end
    end
endmodule
`default_nettype wire

// ### imcm_conn_mgr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "imcm_defs.vh"
module imcm_conn_mgr_monitor (
    input wire ref_clk,
    input wire reset,
    input wire is_input_dev,
    input wire remote_chassis,
    input wire req_valid,
    input wire [1:0] req_kind,
    input wire [1:0] req_slot,
    input wire [`IMCM_CFG_W-1:0] req_cfg,
    input wire req_rev_sel,
    input wire ans_valid,
    input wire [1:0] ans_code,
    input wire [`IMCM_OWN_N-1:0] owner_conn,
    input wire [`IMCM_CFG_W-1:0] cur_cfg,
    input wire [`IMCM_LSN_N-1:0] listen_conn,
    input wire conv_done,
    input wire mcast_valid,
    input wire mcast_fresh,
    input wire net_send
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire own_rq = req_valid && req_kind == `IMCM_REQ_OWNER;
    // owners other than the requesting slot
    wire other  = |(owner_conn & ~(4'h1 << req_slot));
    a_ans_one_cycle: assert property (req_valid && req_kind != `IMCM_REQ_DROP |=> ans_valid)
        else $error("no answer one cycle after request");
    a_listen_needs_owner: assert property (req_valid && req_kind == `IMCM_REQ_LISTEN && owner_conn == 0
        |=> ans_code == `IMCM_ANS_REJ && listen_conn == 0) else $error("listener taken without owner");
    a_listen_drop_all: assert property ($fell(|owner_conn) |=> listen_conn == 0)
        else $error("listeners kept after last owner left");
    a_mcast_with_owner: assert property (mcast_valid |-> $past(owner_conn) != 0)
        else $error("multicast without owner");
    a_mismatch_refused: assert property (own_rq && req_rev_sel && other && req_cfg != cur_cfg
        |=> ans_code == `IMCM_ANS_REJ && $stable(cur_cfg)) else $error("differing config taken");
    a_rev_zero_refused: assert property (own_rq && !req_rev_sel && other |=> ans_code == `IMCM_ANS_REJ)
        else $error("selector zero owner taken");
    a_single_owner_only: assert property (own_rq && !is_input_dev && other |=> ans_code == `IMCM_ANS_REJ)
        else $error("second owner on output device");
    a_net_send_resend: assert property (net_send |-> mcast_valid && !mcast_fresh && remote_chassis)
        else $error("network send outside packet resend");
    a_fresh_after_conv: assert property (conv_done |-> ##2 ((mcast_valid && mcast_fresh) || $past(owner_conn) == 0))
        else $error("fresh multicast missing after conversion");
endmodule
bind imcm_conn_mgr imcm_conn_mgr_monitor u_mon (.ref_clk, .reset, .is_input_dev, .remote_chassis,
    .req_valid, .req_kind, .req_slot, .req_cfg, .req_rev_sel, .ans_valid, .ans_code, .owner_conn,
    .cur_cfg, .listen_conn, .conv_done, .mcast_valid, .mcast_fresh, .net_send);
`default_nettype wire

// ### input_multicast_connection_manager_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "imcm_defs.vh"
module input_multicast_connection_manager_bench;
    typedef struct packed {logic [1:0] k; logic [1:0] s; logic [31:0] c; logic r;
        logic [1:0] a; logic [3:0] o; logic [3:0] l;} imcm_row_t;
    localparam logic [31:0] A = 32'h0000_a5a5, B = 32'h0000_a5a4, C = 32'h0000_3c3c;
    imcm_row_t rows [8] = '{'{2'h2, 2'h3, A, 1'b1, 2'h2, 4'h0, 4'h0}, '{2'h1, 2'h0, A, 1'b1, 2'h1, 4'h1, 4'h0},
        '{2'h1, 2'h1, A, 1'b1, 2'h1, 4'h3, 4'h0}, '{2'h1, 2'h2, B, 1'b1, 2'h2, 4'h3, 4'h0},
        '{2'h1, 2'h2, A, 1'b0, 2'h2, 4'h3, 4'h0}, '{2'h2, 2'h3, A, 1'b1, 2'h1, 4'h3, 4'h8},
        '{2'h3, 2'h0, A, 1'b1, 2'h0, 4'h2, 4'h8}, '{2'h3, 2'h1, A, 1'b1, 2'h0, 4'h0, 4'h0}};
    logic ref_clk = 1'b0, reset = 1'b1, is_input_dev = 1'b1, req_valid = 1'b0, req_rev_sel = 1'b1;
    logic remote_chassis = 1'b1;
    logic [1:0] req_kind = 2'h0, req_slot = 2'h0;
    logic [31:0] req_cfg = 32'h0;
    wire ans_valid, conv_start, conv_done, mcast_valid, mcast_fresh, net_send;
    wire [1:0] ans_code;
    wire [3:0] owner_conn, listen_conn;
    wire [31:0] cur_cfg;
    wire [127:0] conv_data, mcast_data;
    wire [7:0] mcast_status;
    int miscompares = 0, n_compared = 0, n_conv = 0;
    always #5 ref_clk = ~ref_clk;
    imcm_conn_mgr #(.TICK_CYCLES(8)) u_dut (.ref_clk(ref_clk), .reset(reset), .is_input_dev(is_input_dev),
        .remote_chassis(remote_chassis), .req_valid(req_valid), .req_kind(req_kind),
        .sample_interval(16'h0002), .packet_interval(16'h0001),
        .req_slot(req_slot), .req_cfg(req_cfg), .req_rev_sel(req_rev_sel), .ans_valid(ans_valid),
        .ans_code(ans_code), .owner_conn(owner_conn), .listen_conn(listen_conn), .cur_cfg(cur_cfg),
        .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data), .mcast_valid(mcast_valid),
        .mcast_fresh(mcast_fresh), .mcast_data(mcast_data), .mcast_status(mcast_status), .net_send(net_send));
    imcm_conv_model u_conv (.ref_clk(ref_clk), .conv_start(conv_start), .conv_done(conv_done),
        .conv_data(conv_data));
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("compared=%0d miscompares=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // answer lands exactly one cycle after the request edge
    task automatic issue(input logic [1:0] k, input logic [1:0] s, input logic [31:0] c, input logic r);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_kind <= k;
        req_slot <= s;
        req_cfg <= c;
        req_rev_sel <= r;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        #1;
    endtask
    // bounded wait for the next multicast pulse, counting conversions on the way
    task automatic wait_mcast;
        int i;
        n_conv = 0;
        i = 0;
        do begin
            @(posedge ref_clk);
            #1;
            if (conv_start) n_conv++;
            i++;
        end while (!mcast_valid && i < 1000);
        if (!mcast_valid) begin
            miscompares++;
            end_sim();
        end
    endtask
    initial begin
        #1000000;
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            issue(rows[i].k, rows[i].s, rows[i].c, rows[i].r);
            chk(ans_valid, rows[i].a != 2'h0);
            if (rows[i].a != 2'h0) chk(ans_code, rows[i].a);
            chk(owner_conn, rows[i].o);
            if (i > 0) chk(cur_cfg, A);
            @(posedge ref_clk);
            #1;
            chk(listen_conn, rows[i].l);
        end
        issue(2'h1, 2'h0, A, 1'b1);
        issue(2'h1, 2'h0, C, 1'b1);
        chk(ans_code, 2'h1);
        chk(cur_cfg, C);
        issue(2'h1, 2'h1, C, 1'b1);
        chk(ans_code, 2'h1);
        chk(owner_conn, 4'h3);
        // inhibit both owners, apply the same change, then reconnect
        issue(2'h3, 2'h0, C, 1'b1);
        issue(2'h3, 2'h1, C, 1'b1);
        issue(2'h1, 2'h0, A, 1'b1);
        issue(2'h1, 2'h1, A, 1'b1);
        chk(ans_code, 2'h1);
        chk({owner_conn, cur_cfg}, {4'h3, A});
        issue(2'h3, 2'h1, A, 1'b1);
        chk(owner_conn, 4'h1);
        @(posedge ref_clk);
        is_input_dev <= 1'b0;
        issue(2'h1, 2'h1, A, 1'b1);
        chk(ans_code, 2'h2);
        chk(owner_conn, 4'h1);
        @(posedge ref_clk);
        reset <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk({owner_conn, ans_code, ans_valid, mcast_valid}, 8'h0);
        @(posedge ref_clk);
        reset <= 1'b0;
        is_input_dev <= 1'b1;
        issue(2'h1, 2'h0, A, 1'b1);
        chk({ans_valid, ans_code, owner_conn}, {1'b1, 2'h1, 4'h1});
        // both timers expire together first: stale resend, then fresh sample
        wait_mcast();
        chk({mcast_fresh, mcast_status, net_send}, {1'b0, 8'h21, 1'b1});
        chk(mcast_data, 128'h0);
        wait_mcast();
        chk(n_conv, 1);
        chk({mcast_fresh, mcast_status, net_send}, {1'b1, 8'h31, 1'b0});
        chk(mcast_data, {8{16'h0001}});
        wait_mcast();
        chk(n_conv, 0);
        chk({mcast_fresh, net_send}, 2'b01);
        chk(mcast_data, {8{16'h0001}});
        @(posedge ref_clk);
        remote_chassis <= 1'b0;
        wait_mcast();
        chk({mcast_fresh, mcast_status, net_send}, {1'b0, 8'h01, 1'b0});
        wait_mcast();
        chk({mcast_fresh, mcast_status}, {1'b1, 8'h11});
        chk(mcast_data, {8{16'h0002}});
        issue(2'h3, 2'h0, A, 1'b1);
        n_conv = 0;
        repeat (40) begin
            @(posedge ref_clk);
            #1;
            if (mcast_valid || conv_start) n_conv++;
        end
        chk(n_conv, 0);
        end_sim();
    end
endmodule
`default_nettype wire
